//--- verilog/psl_pkg.sv
package psl_pkg;

  // Pad order inside the dual-use pin vectors
  localparam int unsigned PAD_COUNT  = 6;
  localparam int unsigned PAD_COL    = 0;
  localparam int unsigned PAD_CRS    = 1;
  localparam int unsigned PAD_INT    = 2;
  localparam int unsigned PAD_LINK   = 3;
  localparam int unsigned PAD_SPEED  = 4;
  localparam int unsigned PAD_DUPLEX = 5;

  // One bit per pad: 1 = pull-up type, 0 = pull-down type
  localparam logic [5:0] PAD_PULL_UP_MAP = 6'h3C;

  // Register bus geometry
  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 32;
  localparam int unsigned IDX_W  = 6;

  // Register indices; byte address is four times the index
  localparam logic [IDX_W-1:0] IDX_CONTROL    = 6'h00;
  localparam logic [IDX_W-1:0] IDX_SPECIAL    = 6'h1F;
  localparam logic [IDX_W-1:0] IDX_IRQ_STATUS = 6'h20;
  localparam logic [IDX_W-1:0] IDX_IRQ_MASK   = 6'h21;
  localparam logic [IDX_W-1:0] IDX_STRAP_VIEW = 6'h22;

  // Control register fields
  localparam int unsigned CTRL_SPEED_BIT  = 13;
  localparam int unsigned CTRL_DUPLEX_BIT = 8;

  // Special register: interrupt pin polarity, 1 = active high
  localparam int unsigned SPC_INT_POL_BIT   = 9;
  localparam logic        SPC_INT_POL_RESET = 1'b0;

  // Interrupt status and mask layout
  localparam int unsigned EVT_W        = 4;
  localparam int unsigned EVT_LINK     = 0;
  localparam int unsigned EVT_SPEED    = 1;
  localparam int unsigned EVT_DUPLEX   = 2;
  localparam int unsigned EVT_COLL     = 3;
  localparam logic [EVT_W-1:0] IRQ_STATUS_RESET = 4'h0;
  localparam logic [EVT_W-1:0] IRQ_MASK_RESET   = 4'h0;

  // Strap view layout
  localparam int unsigned STRAP_W          = 6;
  localparam int unsigned STRAP_RMII       = 0;
  localparam int unsigned STRAP_BTB        = 1;
  localparam int unsigned STRAP_PHY_ADDRESS_BIT0     = 2;
  localparam int unsigned STRAP_SPEED      = 3;
  localparam int unsigned STRAP_DUPLEX     = 4;
  localparam int unsigned STRAP_TEST       = 5;

endpackage : psl_pkg

//--- verilog/psl_pad_if.sv
`timescale 1ns/1ps

interface psl_pad_if;
  logic in_reset;
  logic drive_val;
  logic strap;

  modport core (
    output in_reset,
    output drive_val,
    input  strap
  );

  modport pad (
    input  in_reset,
    input  drive_val,
    output strap
  );
endinterface : psl_pad_if

//--- verilog/psl_pad.sv
`timescale 1ns/1ps

module psl_pad #(
  parameter bit PULL_UP = 1'b0
) (
  input  wire logic clk_i,
  psl_pad_if.pad    pif,
  input  wire logic pin_in_i,
  output logic      pin_out_o,
  output logic      pin_oe_n_o,
  output logic      pull_up_en_o,
  output logic      pull_down_en_o
);
  import psl_pkg::*;

  logic strap;
  logic next_strap;
  logic next_out;
  logic next_oe_n;
  logic next_pu;
  logic next_pd;

  always_comb begin
    // Follow the pin during reset, then freeze until the next reset
    next_strap = pif.in_reset ? pin_in_i : strap;
    next_out   = pif.in_reset ? 1'b0 : pif.drive_val;
    next_oe_n  = pif.in_reset;
    next_pu    = pif.in_reset & PULL_UP;
    next_pd    = pif.in_reset & ~PULL_UP;
  end

  always_ff @(posedge clk_i) begin
    strap          <= next_strap;
    pin_out_o      <= next_out;
    pin_oe_n_o     <= next_oe_n;
    pull_up_en_o   <= next_pu;
    pull_down_en_o <= next_pd;
  end

  assign pif.strap = strap;

endmodule : psl_pad

//--- verilog/psl_top.sv
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps

module psl_top (
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  // Dual-use pads
  input  wire logic [psl_pkg::PAD_COUNT-1:0] pad_in_i,
  output logic      [psl_pkg::PAD_COUNT-1:0] pad_out_o,
  output logic      [psl_pkg::PAD_COUNT-1:0] pad_oe_n_o,
  output logic      [psl_pkg::PAD_COUNT-1:0] pad_pull_up_en_o,
  output logic      [psl_pkg::PAD_COUNT-1:0] pad_pull_down_en_o,
  // Transceiver core status
  input  wire logic                          collision_i,
  input  wire logic                          carrier_sense_i,
  input  wire logic                          link_up_i,
  input  wire logic                          speed_100_i,
  input  wire logic                          full_duplex_i,
  // Latched configuration toward the core
  output logic                               rmii_mode_o,
  output logic                               back_to_back_select_o,
  output logic                               phy_address_bit0_o,
  output logic                               speed_strap_o,
  output logic                               duplex_strap_o,
  output logic                               test_mode_o,
  output logic                               ctrl_speed_o,
  output logic                               ctrl_duplex_o,
  // Register port
  input  wire logic [psl_pkg::ADDR_W-1:0]    reg_addr_i,
  input  wire logic [psl_pkg::DATA_W-1:0]    reg_wdata_i,
  input  wire logic                          reg_wr_i,
  input  wire logic                          reg_rd_i,
  output logic      [psl_pkg::DATA_W-1:0]    reg_rdata_o,
  // Interrupt
  output logic                               irq_o
);
  import psl_pkg::*;

  function automatic logic reg_hit(
    input logic [ADDR_W-1:0] addr,
    input logic [IDX_W-1:0]  idx
  );
    reg_hit = (addr == {idx, 2'h0});
  endfunction : reg_hit

  // ---------------------------------------------------------------
  // Pads
  // ---------------------------------------------------------------
  logic [PAD_COUNT-1:0] drive_vec;
  logic [PAD_COUNT-1:0] strap_vec;

  for (genvar g = 0; g < PAD_COUNT; g++) begin : g_pad
    psl_pad_if pif ();

    assign pif.in_reset  = rst_i;
    assign pif.drive_val = drive_vec[g];
    assign strap_vec[g]  = pif.strap;

    psl_pad #(
      .PULL_UP (PAD_PULL_UP_MAP[g])
    ) u_pad (
      .clk_i          (clk_i),
      .pif            (pif),
      .pin_in_i       (pad_in_i[g]),
      .pin_out_o      (pad_out_o[g]),
      .pin_oe_n_o     (pad_oe_n_o[g]),
      .pull_up_en_o   (pad_pull_up_en_o[g]),
      .pull_down_en_o (pad_pull_down_en_o[g])
    );
  end

  // ---------------------------------------------------------------
  // Strap decode
  // ---------------------------------------------------------------
  always_comb begin
    rmii_mode_o           = strap_vec[PAD_COL];
    // Back-to-back is meaningless without the reduced interface
    back_to_back_select_o = strap_vec[PAD_CRS] & strap_vec[PAD_COL];
    phy_address_bit0_o    = strap_vec[PAD_INT];
    speed_strap_o         = strap_vec[PAD_SPEED];
    duplex_strap_o        = strap_vec[PAD_DUPLEX];
    test_mode_o           = ~strap_vec[PAD_LINK];
  end

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  logic             ctrl_speed;
  logic             ctrl_duplex;
  logic             int_pol;
  logic [EVT_W-1:0] irq_status;
  logic [EVT_W-1:0] irq_mask;
  logic [DATA_W-1:0] rdata;

  logic             next_ctrl_speed;
  logic             next_ctrl_duplex;
  logic             next_int_pol;
  logic [EVT_W-1:0] next_irq_status;
  logic [EVT_W-1:0] next_irq_mask;
  logic [DATA_W-1:0] next_rdata;

  // Previous core levels for change detection
  logic             prev_link;
  logic             prev_speed;
  logic             prev_duplex;
  logic             prev_coll;
  logic [EVT_W-1:0] events;
  logic [EVT_W-1:0] w1c;

  always_comb begin
    events             = '0;
    events[EVT_LINK]   = link_up_i ^ prev_link;
    events[EVT_SPEED]  = speed_100_i ^ prev_speed;
    events[EVT_DUPLEX] = full_duplex_i ^ prev_duplex;
    events[EVT_COLL]   = collision_i & ~prev_coll;
  end

  always_comb begin
    w1c = '0;
    if (reg_wr_i && reg_hit(reg_addr_i, IDX_IRQ_STATUS)) begin
      w1c = reg_wdata_i[EVT_W-1:0];
    end
  end

  always_comb begin
    next_ctrl_speed  = ctrl_speed;
    next_ctrl_duplex = ctrl_duplex;
    next_int_pol     = int_pol;
    next_irq_mask    = irq_mask;
    // A change in the clearing cycle is kept
    next_irq_status  = (irq_status & ~w1c) | events;
    if (rst_i) begin
      // Control bits take the strap levels seen on the pins in reset
      next_ctrl_speed  = pad_in_i[PAD_SPEED];
      next_ctrl_duplex = pad_in_i[PAD_DUPLEX];
      next_int_pol     = SPC_INT_POL_RESET;
      next_irq_mask    = IRQ_MASK_RESET;
      next_irq_status  = IRQ_STATUS_RESET;
    end else if (reg_wr_i) begin
      if (reg_hit(reg_addr_i, IDX_CONTROL)) begin
        next_ctrl_speed  = reg_wdata_i[CTRL_SPEED_BIT];
        next_ctrl_duplex = reg_wdata_i[CTRL_DUPLEX_BIT];
      end
      if (reg_hit(reg_addr_i, IDX_SPECIAL)) begin
        next_int_pol = reg_wdata_i[SPC_INT_POL_BIT];
      end
      if (reg_hit(reg_addr_i, IDX_IRQ_MASK)) begin
        next_irq_mask = reg_wdata_i[EVT_W-1:0];
      end
    end
  end

  always_comb begin
    next_rdata = '0;
    if (!rst_i && reg_rd_i) begin
      if (reg_hit(reg_addr_i, IDX_CONTROL)) begin
        next_rdata[CTRL_SPEED_BIT]  = ctrl_speed;
        next_rdata[CTRL_DUPLEX_BIT] = ctrl_duplex;
      end else if (reg_hit(reg_addr_i, IDX_SPECIAL)) begin
        next_rdata[SPC_INT_POL_BIT] = int_pol;
      end else if (reg_hit(reg_addr_i, IDX_IRQ_STATUS)) begin
        next_rdata[EVT_W-1:0] = irq_status;
      end else if (reg_hit(reg_addr_i, IDX_IRQ_MASK)) begin
        next_rdata[EVT_W-1:0] = irq_mask;
      end else if (reg_hit(reg_addr_i, IDX_STRAP_VIEW)) begin
        next_rdata[STRAP_RMII]   = rmii_mode_o;
        next_rdata[STRAP_BTB]    = back_to_back_select_o;
        next_rdata[STRAP_PHY_ADDRESS_BIT0] = phy_address_bit0_o;
        next_rdata[STRAP_SPEED]  = speed_strap_o;
        next_rdata[STRAP_DUPLEX] = duplex_strap_o;
        next_rdata[STRAP_TEST]   = test_mode_o;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    ctrl_speed  <= next_ctrl_speed;
    ctrl_duplex <= next_ctrl_duplex;
    int_pol     <= next_int_pol;
    irq_status  <= next_irq_status;
    irq_mask    <= next_irq_mask;
    rdata       <= next_rdata;
  end

  // Change detectors start from the live levels so reset release is quiet
  logic next_prev_link;
  logic next_prev_speed;
  logic next_prev_duplex;
  logic next_prev_coll;

  always_comb begin
    next_prev_link   = link_up_i;
    next_prev_speed  = speed_100_i;
    next_prev_duplex = full_duplex_i;
    next_prev_coll   = collision_i;
  end

  always_ff @(posedge clk_i) begin
    prev_link   <= next_prev_link;
    prev_speed  <= next_prev_speed;
    prev_duplex <= next_prev_duplex;
    prev_coll   <= next_prev_coll;
  end

  // ---------------------------------------------------------------
  // Interrupt and pad drive values
  // ---------------------------------------------------------------
  logic irq_level;

  always_comb begin
    irq_level = |(irq_status & irq_mask);
  end

  always_comb begin
    drive_vec             = '0;
    drive_vec[PAD_COL]    = collision_i;
    drive_vec[PAD_CRS]    = carrier_sense_i;
    // Polarity bit clear gives the active-low interrupt pin
    drive_vec[PAD_INT]    = int_pol ? irq_level : ~irq_level;
    drive_vec[PAD_LINK]   = ~link_up_i;
    drive_vec[PAD_SPEED]  = ~speed_100_i;
    drive_vec[PAD_DUPLEX] = ~full_duplex_i;
  end

  assign ctrl_speed_o  = ctrl_speed;
  assign ctrl_duplex_o = ctrl_duplex;
  assign reg_rdata_o   = rdata;
  assign irq_o         = irq_level;

endmodule : psl_top

//--- dv/psl_assertions.sv
`timescale 1ns/1ps

module psl_assertions (
  input wire logic                          clk_i,
  input wire logic                          rst_i,
  input wire logic [psl_pkg::PAD_COUNT-1:0] pad_in_i,
  input wire logic [psl_pkg::PAD_COUNT-1:0] pad_out_o,
  input wire logic [psl_pkg::PAD_COUNT-1:0] pad_oe_n_o,
  input wire logic [psl_pkg::PAD_COUNT-1:0] pad_pull_up_en_o,
  input wire logic [psl_pkg::PAD_COUNT-1:0] pad_pull_down_en_o,
  input wire logic                          collision_i,
  input wire logic                          carrier_sense_i,
  input wire logic                          link_up_i,
  input wire logic                          speed_100_i,
  input wire logic                          full_duplex_i,
  input wire logic                          rmii_mode_o,
  input wire logic                          back_to_back_select_o,
  input wire logic                          phy_address_bit0_o,
  input wire logic                          speed_strap_o,
  input wire logic                          duplex_strap_o,
  input wire logic                          test_mode_o,
  input wire logic                          ctrl_speed_o,
  input wire logic                          ctrl_duplex_o
);
  import psl_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_pulls_in_reset: assert property (
    $fell(rst_i) |-> $past(pad_oe_n_o) == 6'h3F && $past(pad_pull_up_en_o) == PAD_PULL_UP_MAP
      && $past(pad_pull_down_en_o) == ~PAD_PULL_UP_MAP)
    else $error("pads not pulled inputs during reset");
  a_pads_driven: assert property (
    !$past(rst_i) |-> pad_oe_n_o == 6'h00 && (pad_pull_up_en_o | pad_pull_down_en_o) == 6'h00)
    else $error("pads not driving after reset");
  a_rmii_latch: assert property (
    $fell(rst_i) |-> rmii_mode_o == $past(pad_in_i[PAD_COL])
      && phy_address_bit0_o == $past(pad_in_i[PAD_INT]))
    else $error("mode or address strap wrong");
  a_btb_gate: assert property (
    $fell(rst_i) |-> back_to_back_select_o == ($past(pad_in_i[PAD_CRS]) && rmii_mode_o))
    else $error("back to back strap wrong");
  a_test_select: assert property (
    $fell(rst_i) |-> test_mode_o == !$past(pad_in_i[PAD_LINK]))
    else $error("test mode strap wrong");
  a_ctrl_load: assert property (
    $fell(rst_i) |-> {ctrl_speed_o, ctrl_duplex_o, speed_strap_o, duplex_strap_o}
      == {2{$past(pad_in_i[PAD_SPEED]), $past(pad_in_i[PAD_DUPLEX])}})
    else $error("speed or duplex strap wrong");
  a_strap_stable: assert property (
    !$past(rst_i) |-> $stable({rmii_mode_o, back_to_back_select_o, phy_address_bit0_o,
      speed_strap_o, duplex_strap_o, test_mode_o}))
    else $error("latched strap changed");
  a_mac_pins: assert property (
    !$past(rst_i) |-> pad_out_o[1:0] == {$past(carrier_sense_i), $past(collision_i)})
    else $error("collision or carrier pin wrong");
  a_led_levels: assert property (
    !$past(rst_i) |-> pad_out_o[5:3] == ~{$past(full_duplex_i), $past(speed_100_i), $past(link_up_i)})
    else $error("indicator pin level wrong");
endmodule : psl_assertions

//--- dv/psl_board.sv
`timescale 1ns/1ps

module psl_board (
  input  wire logic       clk_i,
  input  wire logic [5:0] fit_i,
  input  wire logic [5:0] val_i,
  input  wire logic [5:0] out_i,
  input  wire logic [5:0] oe_n_i,
  input  wire logic [5:0] pu_i,
  input  wire logic [5:0] pd_i,
  output logic      [5:0] level_o
);
  logic [5:0] last = 6'h00;
  logic [5:0] idle;
  // A pad nobody holds flips each cycle so it never looks like a clean level
  assign idle = (fit_i & val_i) | (~fit_i & (pu_i | (~pd_i & ~last)));
  assign level_o = (~oe_n_i & out_i) | (oe_n_i & idle);
  always_ff @(posedge clk_i) begin
    last <= level_o;
  end
endmodule : psl_board

//--- dv/tb_top.sv
`timescale 1ns/1ps

module tb_top;
  import psl_pkg::*;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [5:0]  pad_in, pad_out, oe_n, pu, pd, eff, f, v;
  logic [5:0]  fit = 6'h00, val = 6'h00;
  logic        col = 1'b0, carrier_sense_out = 1'b0, link = 1'b0, spd = 1'b0, fdx = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, seed = 32'h7C2B;
  logic        wr = 1'b0, rd = 1'b0, rd_seen = 1'b0, irq;
  logic [31:0] exp_q[$];
  int          fails = 0, comparisons = 0;

  psl_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .pad_in_i(pad_in), .pad_out_o(pad_out),
    .pad_oe_n_o(oe_n), .pad_pull_up_en_o(pu), .pad_pull_down_en_o(pd), .collision_i(col),
    .carrier_sense_i(carrier_sense_out), .link_up_i(link), .speed_100_i(spd), .full_duplex_i(fdx),
    .rmii_mode_o(), .back_to_back_select_o(), .phy_address_bit0_o(), .speed_strap_o(),
    .duplex_strap_o(), .test_mode_o(), .ctrl_speed_o(), .ctrl_duplex_o(), .reg_addr_i(addr),
    .reg_wdata_i(wdata), .reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdata), .irq_o(irq));
  psl_board i_board (.clk_i(clk_i), .fit_i(fit), .val_i(val), .out_i(pad_out), .oe_n_i(oe_n),
    .pu_i(pu), .pd_i(pd), .level_o(pad_in));

  initial forever #5 clk_i = ~clk_i;

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check_pin(input string what, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, e, s);
    end
  endtask : check_pin

  task automatic check_rd(input logic [31:0] e);
    check_pin("read data", e, rdata);
  endtask : check_rd

  task automatic final_report;
    if (fails == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : final_report

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    addr <= a;
    rd <= 1'b1;
    exp_q.push_back(e);
    @(posedge clk_i);
    rd <= 1'b0;
  endtask : rd_reg

  task automatic wait_look(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask : wait_look

  always @(posedge clk_i) rd_seen <= rd && !rst_i;
  // Read data stand only in the cycle after the strobe, so look mid-cycle
  always @(negedge clk_i) if (rd_seen) check_rd(exp_q.pop_front());

  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    final_report();
  end

  initial begin
    @(posedge clk_i);
    for (int i = 0; i < 6; i++) begin
      seed = lfsr(seed);
      f = seed[5:0];
      v = seed[13:8];
      v[3] = (i == 0) ? 1'b0 : 1'b1;
      f[3] = f[3] | (i == 0);
      fit <= f;
      val <= v;
      rst_i <= 1'b1;
      repeat (5) @(posedge clk_i);
      rst_i <= 1'b0;
      eff = (f & v) | (~f & PAD_PULL_UP_MAP);
      rd_reg(8'h88, {26'h0, ~eff[3], eff[5], eff[4], eff[2], eff[1] & eff[0], eff[0]});
      rd_reg(8'h00, {18'h0, eff[4], 4'h0, eff[5], 8'h00});
    end
    wr_reg(8'h88, 32'hFFFFFFFF);
    wr_reg(8'h00, 32'h00002100);
    rd_reg(8'h00, 32'h00002100);
    rd_reg(8'h88, {26'h0, ~eff[3], eff[5], eff[4], eff[2], eff[1] & eff[0], eff[0]});
    rd_reg(8'h40, 32'h0);
    rd_reg(8'h81, 32'h0);
    wr_reg(8'h84, 32'h1);
    link <= 1'b1;
    wait_look(3);
    check_pin("irq", 1, irq);
    check_pin("int pin", 0, pad_out[PAD_INT]);
    rd_reg(8'h80, 32'h1);
    wr_reg(8'h80, 32'h1);
    col <= 1'b1;
    wait_look(3);
    check_pin("irq", 0, irq);
    check_pin("int pin", 1, pad_out[PAD_INT]);
    rd_reg(8'h80, 32'h8);
    wr_reg(8'h7C, 32'h200);
    wait_look(2);
    check_pin("int pin", 0, pad_out[PAD_INT]);
    link <= 1'b0;
    wait_look(3);
    check_pin("int pin", 1, pad_out[PAD_INT]);
    for (int i = 0; i < 8; i++) begin
      seed = lfsr(seed);
      @(posedge clk_i);
      {col, carrier_sense_out, link, spd, fdx} <= seed[4:0];
      wait_look(2);
      check_pin("indicators", {~fdx, ~spd, ~link, 1'b0, carrier_sense_out, col}, pad_out & 6'h3B);
    end
    wait_look(2);
    final_report();
  end
endmodule : tb_top

bind psl_top psl_assertions i_chk (.clk_i, .rst_i, .pad_in_i, .pad_out_o, .pad_oe_n_o,
  .pad_pull_up_en_o, .pad_pull_down_en_o, .collision_i, .carrier_sense_i, .link_up_i,
  .speed_100_i, .full_duplex_i, .rmii_mode_o, .back_to_back_select_o, .phy_address_bit0_o,
  .speed_strap_o, .duplex_strap_o, .test_mode_o, .ctrl_speed_o, .ctrl_duplex_o);
